// ---- src/rate_config_pkg.sv ----
package rate_config_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] TEST_FIXED_VALUE_ADDR           = 8'hBF;
    localparam logic [7:0] PORT_THREE_CONTROL_A_ADDR        = 8'hCF;
    localparam logic [7:0] PORT_THREE_CONTROL_B_ADDR        = 8'hDF;
    localparam logic [7:0] TEST_FIXED_VALUE_THREE_ADDR      = 8'hEF;
    localparam logic [7:0] TEST_AND_PORT_FOUR_CONTROL_ADDR  = 8'hFF;

    // ****************************************************************
    // Fixed and reset values
    // ****************************************************************
    localparam logic [7:0] TEST_FIXED_VALUE                 = 8'h80;
    localparam logic [7:0] TEST_FIXED_VALUE_THREE           = 8'h32;
    localparam logic [7:0] TEST_AND_PORT_FOUR_VALUE         = 8'h00;
    localparam logic [4:0] CONTROL_A_RESERVED_VALUE         = 5'h15;
    localparam logic [5:0] CONTROL_B_RESERVED_VALUE         = 6'h2C;
    localparam logic [7:0] UNMAPPED_READ_VALUE              = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int HALF_DUPLEX_BIT   = 7;
    localparam int FLOW_CONTROL_BIT  = 6;
    localparam int SPEED_10BT_BIT    = 5;
    localparam int MAC_MODE_BIT      = 6;
    localparam int RATE_CODE_MSB     = 6;

    // ****************************************************************
    // Rate code decoding
    // ****************************************************************
    localparam int RATE_WIDTH = 17;
    localparam logic [6:0] CODE_UNLIMITED       = 7'h00;
    localparam logic [6:0] CODE_MAX_100BT       = 7'h63;
    localparam logic [6:0] CODE_FULL_100BT      = 7'h64;
    localparam logic [6:0] CODE_MAX_10BT        = 7'h09;
    localparam logic [6:0] CODE_FULL_10BT       = 7'h0A;
    localparam logic [6:0] CODE_SUB_MBPS_FIRST  = 7'h65;
    localparam logic [6:0] CODE_SUB_MBPS_LAST   = 7'h73;
    localparam logic [6:0] CODE_SUB_MBPS_BASE   = 7'h64;
    localparam logic [RATE_WIDTH-1:0] KBPS_PER_MBPS   = 17'h003E8;
    localparam logic [RATE_WIDTH-1:0] KBPS_PER_STEP   = 17'h00040;
    localparam logic [RATE_WIDTH-1:0] FULL_RATE_100BT = 17'h186A0;
    localparam logic [RATE_WIDTH-1:0] FULL_RATE_10BT  = 17'h02710;

endpackage

// ---- src/rate_code_decoder.sv ----
`timescale 1ns/10ps

module rate_code_decoder #(
    parameter int RATE_WIDTH = rate_config_pkg::RATE_WIDTH
) (
    input  wire logic [6:0]            rate_code,
    input  wire logic                  speed_10bt,
    output logic      [RATE_WIDTH-1:0] rate_kbps
);

    logic [RATE_WIDTH-1:0] full_rate;
    logic [RATE_WIDTH-1:0] code_wide;
    logic [RATE_WIDTH-1:0] step_wide;

    always_comb begin
        full_rate = speed_10bt ? rate_config_pkg::FULL_RATE_10BT  // RULE14
                               : rate_config_pkg::FULL_RATE_100BT;
        code_wide = RATE_WIDTH'(rate_code);
        step_wide = RATE_WIDTH'(rate_code - rate_config_pkg::CODE_SUB_MBPS_BASE);
        if (rate_code == rate_config_pkg::CODE_UNLIMITED) begin
            rate_kbps = full_rate;  // RULE2 RULE5
        end else if (rate_code >= rate_config_pkg::CODE_SUB_MBPS_FIRST &&
                     rate_code <= rate_config_pkg::CODE_SUB_MBPS_LAST) begin
            rate_kbps = RATE_WIDTH'(step_wide * rate_config_pkg::KBPS_PER_STEP);  // RULE3
        end else if (rate_code > rate_config_pkg::CODE_SUB_MBPS_LAST) begin
            rate_kbps = full_rate;  // RULE15
        end else if (speed_10bt) begin
            if (rate_code <= rate_config_pkg::CODE_MAX_10BT) begin
                rate_kbps = RATE_WIDTH'(code_wide * rate_config_pkg::KBPS_PER_MBPS);  // RULE4
            end else begin
                // Code 10 is full rate; 11 to 100 mean nothing at 10BT and also run unlimited.
                rate_kbps = full_rate;  // RULE5
            end
        end else if (rate_code <= rate_config_pkg::CODE_MAX_100BT) begin
            rate_kbps = RATE_WIDTH'(code_wide * rate_config_pkg::KBPS_PER_MBPS);  // RULE1
        end else begin
            rate_kbps = full_rate;  // RULE2
        end
    end

endmodule

// ---- src/rate_config.sv ----
`timescale 1ns/10ps

// How it works
// RULE1: 100BT codes 1-99 give that many Mbps.
// RULE2: 100BT code 0 or 100 is full.
// RULE3: Codes 101-115 give 64 Kbps steps.
// RULE4: 10BT codes 1-9 give that many Mbps.
// RULE5: 10BT code 0 or 10 is full.
// RULE6: Rate code sits in field bits six-zero.
// RULE7: Control A bit 7 selects half duplex.
// RULE8: Control A bit 6 enables flow control.
// RULE9: Control A bit 5 selects 10BT speed.
// RULE10: Control B bit 6 selects MAC mode.
// RULE11: Offset 0xBF reads fixed 0x80, read-only.
// RULE12: Software leaves reserved test fields unchanged.
// RULE13: Only highest-priority queue shapes exactly.
// RULE14: Decoder follows the limited port's speed.
// RULE15: Codes 116-127 mean full port speed.
module rate_config (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [7:0]  limit_field,
    input  wire logic        limit_is_port_three,
    input  wire logic        limit_port_10bt,
    input  wire logic        limit_queue_highest,
    output logic      [16:0] limit_rate_kbps,
    output logic             limit_exact,
    output logic             port_three_half_duplex,
    output logic             port_three_flow_control,
    output logic             port_three_speed_10bt,
    output logic             port_three_mac_mode
);

    // ****************************************************************
    // Register access decode
    // ****************************************************************
    logic write_control_a;
    logic write_control_b;

    // Only the two port-three control bytes hold writable state. Writes to the
    // fixed test bytes and to any other offset fall away here.
    always_comb begin
        write_control_a = reg_wr && (reg_addr == rate_config_pkg::PORT_THREE_CONTROL_A_ADDR);
        write_control_b = reg_wr && (reg_addr == rate_config_pkg::PORT_THREE_CONTROL_B_ADDR);
    end

    // ****************************************************************
    // Port three interface control
    // ****************************************************************
    logic half_duplex_reg;
    logic half_duplex_next;
    logic flow_control_reg;
    logic flow_control_next;
    logic speed_10bt_reg;
    logic speed_10bt_next;
    logic mac_mode_reg;
    logic mac_mode_next;

    // Each field keeps its value until a write to its own byte. The reserved
    // fields of both bytes have no storage at all.
    always_comb begin
        half_duplex_next  = half_duplex_reg;
        flow_control_next = flow_control_reg;
        speed_10bt_next   = speed_10bt_reg;
        mac_mode_next     = mac_mode_reg;
        if (write_control_a) begin
            half_duplex_next  = reg_wdata[rate_config_pkg::HALF_DUPLEX_BIT];   // RULE7
            flow_control_next = reg_wdata[rate_config_pkg::FLOW_CONTROL_BIT];  // RULE8
            speed_10bt_next   = reg_wdata[rate_config_pkg::SPEED_10BT_BIT];    // RULE9
        end
        if (write_control_b) begin
            mac_mode_next = reg_wdata[rate_config_pkg::MAC_MODE_BIT];  // RULE10
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            half_duplex_reg  <= 1'b0;
            flow_control_reg <= 1'b0;
            speed_10bt_reg   <= 1'b0;
            mac_mode_reg     <= 1'b0;
        end else begin
            half_duplex_reg  <= half_duplex_next;
            flow_control_reg <= flow_control_next;
            speed_10bt_reg   <= speed_10bt_next;
            mac_mode_reg     <= mac_mode_next;
        end
    end

    assign port_three_half_duplex  = half_duplex_reg;
    assign port_three_flow_control = flow_control_reg;
    assign port_three_speed_10bt   = speed_10bt_reg;
    assign port_three_mac_mode     = mac_mode_reg;

    // ****************************************************************
    // Register read words
    // ****************************************************************
    logic [7:0] control_a_word;
    logic [7:0] control_b_word;

    // Reserved fields read back their fixed contents whatever was written.
    always_comb begin
        control_a_word = {half_duplex_reg, flow_control_reg, speed_10bt_reg,
                          rate_config_pkg::CONTROL_A_RESERVED_VALUE};  // RULE7 RULE8 RULE9
        control_b_word = {1'b0, mac_mode_reg,
                          rate_config_pkg::CONTROL_B_RESERVED_VALUE};  // RULE10
    end

    // ****************************************************************
    // Register read
    // ****************************************************************
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // The mux reads the flops, so a read in the same cycle as a write to the
    // same byte returns the contents from before the write. The read data
    // stands until the next read strobe.
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            unique case (reg_addr)
                rate_config_pkg::TEST_FIXED_VALUE_ADDR:
                    rdata_next = rate_config_pkg::TEST_FIXED_VALUE;  // RULE11
                rate_config_pkg::PORT_THREE_CONTROL_A_ADDR:
                    rdata_next = control_a_word;  // RULE12
                rate_config_pkg::PORT_THREE_CONTROL_B_ADDR:
                    rdata_next = control_b_word;  // RULE12
                rate_config_pkg::TEST_FIXED_VALUE_THREE_ADDR:
                    rdata_next = rate_config_pkg::TEST_FIXED_VALUE_THREE;  // RULE12
                rate_config_pkg::TEST_AND_PORT_FOUR_CONTROL_ADDR:
                    rdata_next = rate_config_pkg::TEST_AND_PORT_FOUR_VALUE;
                default:
                    rdata_next = rate_config_pkg::UNMAPPED_READ_VALUE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ****************************************************************
    // Rate code selection
    // ****************************************************************
    logic [6:0] rate_code;
    logic       limit_speed_10bt;

    // Bit 7 of a limit byte is reserved, so only the code reaches the decoder.
    // The port-three limit follows its own speed setting, because that speed
    // is held here; the other ports' speeds come in from outside.
    always_comb begin
        rate_code        = limit_field[rate_config_pkg::RATE_CODE_MSB:0];  // RULE6
        limit_speed_10bt = limit_is_port_three ? speed_10bt_reg : limit_port_10bt;  // RULE14
    end

    // ****************************************************************
    // Rate code decoding
    // ****************************************************************
    logic [16:0] decoded_rate;

    rate_code_decoder #(
        .RATE_WIDTH (rate_config_pkg::RATE_WIDTH)
    ) decoder (
        .rate_code  (rate_code),
        .speed_10bt (limit_speed_10bt),
        .rate_kbps  (decoded_rate)
    );

    // ****************************************************************
    // Shaped rate output
    // ****************************************************************
    logic [16:0] rate_reg;
    logic [16:0] rate_next;

    // After reset the output shows the full 100BT rate, which is what the
    // reset code 0 decodes to at the reset speed of port three.
    always_comb begin
        rate_next = decoded_rate;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rate_reg <= rate_config_pkg::FULL_RATE_100BT;  // RULE2
        end else begin
            rate_reg <= rate_next;
        end
    end

    assign limit_rate_kbps = rate_reg;

    // ****************************************************************
    // Exact shaping flag
    // ****************************************************************
    logic exact_reg;
    logic exact_next;

    // Only the highest-priority queue is shaped exactly to the decoded rate;
    // the other queues share what is left by the per-port ratio settings.
    always_comb begin
        exact_next = limit_queue_highest;  // RULE13
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            exact_reg <= 1'b0;
        end else begin
            exact_reg <= exact_next;
        end
    end

    assign limit_exact = exact_reg;

endmodule

// ---- tb/rate_config_sva.sv ----
`timescale 1ns/10ps
module rate_config_sva (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic [7:0]  limit_field,
    input wire logic        limit_is_port_three,
    input wire logic        limit_port_10bt,
    input wire logic        limit_queue_highest,
    input wire logic [16:0] limit_rate_kbps,
    input wire logic        limit_exact,
    input wire logic        port_three_half_duplex,
    input wire logic        port_three_flow_control,
    input wire logic        port_three_speed_10bt,
    input wire logic        port_three_mac_mode
);
    wire logic        spd  = limit_is_port_three ? port_three_speed_10bt : limit_port_10bt;
    wire logic [6:0]  code = limit_field[6:0];
    wire logic [16:0] full = spd ? 17'h02710 : 17'h186A0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_wr(a);
        reg_wr && reg_addr == a;
    endsequence
    AST_HALF: assert property (s_wr(8'hCF) |=>
        port_three_half_duplex == $past(reg_wdata[7])) else $error("bad duplex");
    AST_FLOW: assert property (s_wr(8'hCF) |=>
        port_three_flow_control == $past(reg_wdata[6])) else $error("bad flow control");
    AST_SPEED: assert property (s_wr(8'hCF) |=>
        port_three_speed_10bt == $past(reg_wdata[5])) else $error("bad speed");
    AST_MAC: assert property (s_wr(8'hDF) |=>
        port_three_mac_mode == $past(reg_wdata[6])) else $error("bad mode");
    AST_FIXED: assert property (reg_rd && reg_addr == 8'hBF |=>
        reg_rdata == 8'h80) else $error("bad fixed read");
    AST_MBPS_100: assert property (!spd && code inside {[7'h01:7'h63]} |=>
        limit_rate_kbps == 17'h003E8 * $past(code)) else $error("bad 100 rate");
    AST_MBPS_10: assert property (spd && code inside {[7'h01:7'h09]} |=>
        limit_rate_kbps == 17'h003E8 * $past(code)) else $error("bad 10 rate");
    AST_SUB: assert property (code inside {[7'h65:7'h73]} |=>
        limit_rate_kbps == 17'h00040 * ($past(code) - 7'h64)) else $error("bad sub rate");
    AST_FULL: assert property (code == 7'h00 || code > 7'h73 ||
        (spd ? code == 7'h0A : code == 7'h64) |=> limit_rate_kbps == $past(full))
        else $error("bad full rate");
    AST_EXACT: assert property (1'b1 |=>
        limit_exact == $past(limit_queue_highest)) else $error("bad exact flag");
endmodule

bind rate_config rate_config_sva u_rate_config_sva (.clk, .rst_b, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .limit_field, .limit_is_port_three, .limit_port_10bt,
    .limit_queue_highest, .limit_rate_kbps, .limit_exact, .port_three_half_duplex,
    .port_three_flow_control, .port_three_speed_10bt, .port_three_mac_mode);

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench;
    typedef struct packed {
        logic [7:0]  field;
        logic        slow;
        logic [16:0] rate;
    } row_type;
    logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, limit_field = 8'h00, reg_rdata;
    logic        limit_is_port_three = 1'b0, limit_port_10bt = 1'b0;
    logic        limit_queue_highest = 1'b0, limit_exact;
    logic [16:0] limit_rate_kbps;
    logic [3:0]  p3;
    int          failures = 0, num_checks = 0, cycles = 0;
    row_type     rows [12] = '{
        '{8'h00, 1'b0, 17'h186A0}, '{8'h01, 1'b0, 17'h003E8}, '{8'h63, 1'b0, 17'h182B8},
        '{8'h64, 1'b0, 17'h186A0}, '{8'h65, 1'b0, 17'h00040}, '{8'h73, 1'b1, 17'h003C0},
        '{8'h74, 1'b0, 17'h186A0}, '{8'hFF, 1'b0, 17'h186A0}, '{8'h85, 1'b1, 17'h01388},
        '{8'h09, 1'b1, 17'h02328}, '{8'h0A, 1'b1, 17'h02710}, '{8'h7F, 1'b1, 17'h02710}};
    rate_config u_rate_config (.clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata, .limit_field, .limit_is_port_three, .limit_port_10bt,
        .limit_queue_highest, .limit_rate_kbps, .limit_exact,
        .port_three_half_duplex(p3[3]), .port_three_flow_control(p3[2]),
        .port_three_speed_10bt(p3[1]), .port_three_mac_mode(p3[0]));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            failures++;
            test_done();
        end
    end
    task automatic test_done();
        if (failures == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] want);
        num_checks++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", 17'(reg_rdata), 17'(want));
    endtask
    task automatic dec(input logic [7:0] f, input logic s, input logic t, input logic [16:0] r);
        @(posedge clk);
        limit_field <= f;
        limit_port_10bt <= s;
        limit_is_port_three <= t;
        limit_queue_highest <= f[0];
        @(posedge clk);
        #1 chk("limit_rate_kbps", limit_rate_kbps, r);
        chk("limit_exact", 17'(limit_exact), 17'(f[0]));
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        #1 chk("limit_rate_kbps", limit_rate_kbps, 17'h186A0);
        chk("port_three", 17'(p3), 17'h00000);
        foreach (rows[i]) dec(rows[i].field, rows[i].slow, 1'b0, rows[i].rate);
        wr(8'hBF, 8'h00);
        rd(8'hBF, 8'h80);
        rd(8'hEF, 8'h32);
        rd(8'hFF, 8'h00);
        rd(8'h10, 8'h00);
        wr(8'hCF, 8'hF5);
        #1 chk("port_three", 17'(p3), 17'h0000E);
        rd(8'hCF, 8'hF5);
        wr(8'hDF, 8'h6C);
        #1 chk("port_three", 17'(p3), 17'h0000F);
        rd(8'hDF, 8'h6C);
        dec(8'h05, 1'b0, 1'b1, 17'h01388);
        dec(8'h00, 1'b0, 1'b1, 17'h02710);
        wr(8'hCF, 8'h15);
        #1 chk("port_three", 17'(p3), 17'h00001);
        rd(8'hCF, 8'h15);
        dec(8'h0B, 1'b1, 1'b1, 17'h02AF8);
        @(posedge clk);
        rst_b <= 1'b0;
        #1 chk("port_three", 17'(p3), 17'h00000);
        chk("limit_rate_kbps", limit_rate_kbps, 17'h186A0);
        chk("limit_exact", 17'(limit_exact), 17'h00000);
        chk("reg_rdata", 17'(reg_rdata), 17'h00000);
        @(posedge clk);
        rst_b <= 1'b1;
        rd(8'hDF, 8'h2C);
        dec(8'h73, 1'b0, 1'b1, 17'h003C0);
        test_done();
    end
endmodule
